// ---- logic/omc_mode_controller.sv ----
// operating mode controller with an AXI4-Lite register slave
//
// How it works
// - after reset, once power is ok and the PLL locked, enter mission mode
// - the power-ok status follows the supply comparator, cleared below threshold
// - loss of system power forces brownout mode
// - mission to brownout and back does not restart the processor
// - firmware requests display-only or sleep via the mode control bits
// - brownout disables system-powered resources and selects battery supply
// - brownout keeps the PLL running unchanged, no automatic slowdown
// - returning system power moves any battery mode back to mission
// - a wake on battery power enters brownout mode
// - display-only and sleep are entered under processor request
// - timer, button, pin or receive activity wakes display-only or sleep
// - the wake cause is recorded in a readable sticky register
// - circuit function enables follow the mode table
// - nonvolatile RAM retained always, data RAM only in mission and brownout
// - in display-only the PLL runs only when boost select is active
// - a request in mission mode passes briefly then returns
// - leaving display-only or sleep restarts the processor and clears the requests; display-only exit also resets boost
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
module omc_mode_controller (
   input wire logic clk, // 20 MHz system clock
   input wire logic reset, // asynchronous reset, active high
   input wire logic [15:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [15:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic supplyAboveThreshold, // comparator: supply above 2.8 V
   input wire logic pllLocked, // PLL is stable
   input wire logic wakeTimerExpired, // wake timer timeout
   input wire logic pushbuttonInput, // pushbutton level
   input wire logic edgeWakePin, // edge wake pin
   input wire logic levelWakePinA, // level wake pin a
   input wire logic levelWakePinB, // level wake pin b
   input wire logic serialReceivePin, // serial receive line
   input wire logic opticalReceivePin, // optical receive line
   output logic [2:0] modeCode, // current operating mode
   output logic computeEnable, // compute engine, filter, converter
   output logic coreEnable, // processor, flash, RAM, serial, watchdog
   output logic displayEnable, // display driver and boost
   output logic pllEnable, // PLL running
   output logic batterySupplySelect, // draw supply from battery pin
   output logic dataRamRetain, // data RAM contents kept
   output logic nvRamRetain, // nonvolatile RAM contents kept
   output logic alwaysOnEnable, // temp sensor, wake timer, oscillator
   output logic cpuRestart // pulse: processor restarts at zero
);

   omc_pkg::omc_state_type state_reg;
   omc_pkg::omc_state_type state_next;
   logic systemPowerOk_reg;
   logic displayOnlyRequest_reg;
   logic sleepRequest_reg;
   logic [1:0] displayBoostSelect_reg;
   logic [1:0] displayBoostSelect_next;
   logic [omc_pkg::WAKE_COUNT-1:0] wakeCause_reg;
   logic [omc_pkg::WAKE_COUNT-1:0] wakeEvents;
   logic wakeAny;
   logic leaveLowPower;
   logic awGot_reg;
   logic wGot_reg;
   logic [13:0] writeIndex_reg;
   logic [31:0] writeData_reg;
   logic writeLane0_reg;
   logic writeFire;
   logic writeHit;
   logic [31:0] readData;
   logic readHit;
   logic [2:0] modeCode_next;

   // =====================================================================
   // wake sources
   omc_wake_detect u_wake (
      .clk(clk),
      .reset(reset),
      .wakeSources({opticalReceivePin, serialReceivePin, levelWakePinB, levelWakePinA,
                    edgeWakePin, pushbuttonInput, wakeTimerExpired}),
      .wakeEvents(wakeEvents)
   );

   assign wakeAny = |wakeEvents;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         systemPowerOk_reg <= 1'b0;
      end else begin
         systemPowerOk_reg <= supplyAboveThreshold;
      end
   end

   // =====================================================================
   // mode sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         omc_pkg::POWER_UP: begin
            if (systemPowerOk_reg && pllLocked) begin
               state_next = omc_pkg::MISSION;
            end
         end
         omc_pkg::MISSION: begin
            // forced brownout; no restart on this path
            if (!systemPowerOk_reg) begin
               state_next = omc_pkg::BROWNOUT;
            // request in mission makes a brief pass
            end else if (sleepRequest_reg) begin
               state_next = omc_pkg::SLEEP;
            end else if (displayOnlyRequest_reg) begin
               state_next = omc_pkg::DISPLAY_ONLY;
            end
         end
         omc_pkg::BROWNOUT: begin
            // power back, no restart on return
            if (systemPowerOk_reg) begin
               state_next = omc_pkg::MISSION;
            end else if (sleepRequest_reg) begin
               state_next = omc_pkg::SLEEP;
            end else if (displayOnlyRequest_reg) begin
               state_next = omc_pkg::DISPLAY_ONLY;
            end
         end
         omc_pkg::DISPLAY_ONLY, omc_pkg::SLEEP: begin
            if (systemPowerOk_reg) begin
               state_next = omc_pkg::MISSION;
            end else if (wakeAny) begin
               state_next = omc_pkg::BROWNOUT;
            end
         end
         default: begin
            state_next = omc_pkg::POWER_UP;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= omc_pkg::POWER_UP;
      end else begin
         state_reg <= state_next;
      end
   end

   assign leaveLowPower = (state_reg == omc_pkg::DISPLAY_ONLY || state_reg == omc_pkg::SLEEP)
                          && (state_next != state_reg);

   // restart pulse on leaving low power
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cpuRestart <= 1'b0;
      end else begin
         cpuRestart <= leaveLowPower;
      end
   end

   // =====================================================================
   // circuit function enables, registered from the next mode
   always_comb begin
      case (state_next)
         omc_pkg::MISSION: modeCode_next = omc_pkg::MODE_CODE_MISSION;
         omc_pkg::BROWNOUT: modeCode_next = omc_pkg::MODE_CODE_BROWNOUT;
         omc_pkg::DISPLAY_ONLY: modeCode_next = omc_pkg::MODE_CODE_DISPLAY;
         omc_pkg::SLEEP: modeCode_next = omc_pkg::MODE_CODE_SLEEP;
         default: modeCode_next = omc_pkg::MODE_CODE_POWER_UP;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         modeCode <= omc_pkg::MODE_CODE_POWER_UP;
         computeEnable <= 1'b0;
         coreEnable <= 1'b0;
         displayEnable <= 1'b0;
         dataRamRetain <= 1'b0;
         batterySupplySelect <= 1'b0;
         nvRamRetain <= 1'b1;
         alwaysOnEnable <= 1'b1;
      end else begin
         modeCode <= modeCode_next;
         computeEnable <= (state_next == omc_pkg::MISSION);
         coreEnable <= (state_next == omc_pkg::MISSION) || (state_next == omc_pkg::BROWNOUT);
         displayEnable <= (state_next != omc_pkg::SLEEP) && (state_next != omc_pkg::POWER_UP);
         dataRamRetain <= (state_next == omc_pkg::MISSION) || (state_next == omc_pkg::BROWNOUT);
         nvRamRetain <= 1'b1;
         alwaysOnEnable <= 1'b1;
         batterySupplySelect <= (state_next != omc_pkg::MISSION)
                                && (state_next != omc_pkg::POWER_UP);
      end
   end

   // PLL stays on in brownout, boost decides display-only
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pllEnable <= 1'b1;
      end else begin
         case (state_next)
            omc_pkg::SLEEP: pllEnable <= 1'b0;
            omc_pkg::DISPLAY_ONLY: pllEnable <= (displayBoostSelect_next == omc_pkg::BOOST_ACTIVE);
            default: pllEnable <= 1'b1;
         endcase
      end
   end

   // =====================================================================
   // AXI4-Lite write channel: address and data taken in either order
   assign writeFire = awGot_reg && wGot_reg && !s_axi_bvalid;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         awGot_reg <= 1'b0;
         wGot_reg <= 1'b0;
         writeIndex_reg <= 14'h0000;
         writeData_reg <= 32'h00000000;
         writeLane0_reg <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= omc_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            writeIndex_reg <= s_axi_awaddr[15:2];
            awGot_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            writeData_reg <= s_axi_wdata;
            writeLane0_reg <= s_axi_wstrb[0];
            wGot_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (writeFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= writeHit ? omc_pkg::RESP_OKAY : omc_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            awGot_reg <= 1'b0;
            wGot_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   assign writeHit = (writeIndex_reg == omc_pkg::STATUS_INDEX)
                     || (writeIndex_reg == omc_pkg::WAKE_CAUSE_INDEX)
                     || (writeIndex_reg == omc_pkg::DISPLAY_CFG_INDEX)
                     || (writeIndex_reg == omc_pkg::MODE_CTRL_INDEX);

   // =====================================================================
   // software registers
   // mode requests; cleared when low power is left, a write wins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         displayOnlyRequest_reg <= 1'b0;
         sleepRequest_reg <= 1'b0;
      end else if (writeFire && writeLane0_reg && writeIndex_reg == omc_pkg::MODE_CTRL_INDEX) begin
         displayOnlyRequest_reg <= writeData_reg[omc_pkg::DISPLAY_REQ_BIT];
         sleepRequest_reg <= writeData_reg[omc_pkg::SLEEP_REQ_BIT];
      end else if (leaveLowPower) begin
         displayOnlyRequest_reg <= 1'b0;
         sleepRequest_reg <= 1'b0;
      end
   end

   // boost select reset on display-only exit; sleep keeps display settings
   always_comb begin
      displayBoostSelect_next = displayBoostSelect_reg;
      if (writeFire && writeLane0_reg && writeIndex_reg == omc_pkg::DISPLAY_CFG_INDEX) begin
         displayBoostSelect_next = writeData_reg[omc_pkg::BOOST_LSB +: 2];
      end else if (leaveLowPower && state_reg == omc_pkg::DISPLAY_ONLY) begin
         displayBoostSelect_next = omc_pkg::BOOST_RESET;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         displayBoostSelect_reg <= omc_pkg::BOOST_RESET;
      end else begin
         displayBoostSelect_reg <= displayBoostSelect_next;
      end
   end

   // sticky wake cause, write one to clear, a new event wins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wakeCause_reg <= omc_pkg::WAKE_CAUSE_RESET;
      end else begin
         wakeCause_reg <= (wakeCause_reg
                           & ~((writeFire && writeLane0_reg
                                && writeIndex_reg == omc_pkg::WAKE_CAUSE_INDEX)
                               ? writeData_reg[omc_pkg::WAKE_COUNT-1:0]
                               : omc_pkg::WAKE_CAUSE_RESET))
                          | (((state_reg == omc_pkg::DISPLAY_ONLY || state_reg == omc_pkg::SLEEP)
                              && !systemPowerOk_reg) ? wakeEvents : omc_pkg::WAKE_CAUSE_RESET);
      end
   end

   // =====================================================================
   // AXI4-Lite read channel
   always_comb begin
      readData = 32'h00000000;
      readHit = 1'b1;
      case (s_axi_araddr[15:2])
         omc_pkg::STATUS_INDEX: begin
            readData[omc_pkg::STATUS_MODE_LSB +: 3] = modeCode;
            readData[omc_pkg::STATUS_POWER_OK_BIT] = systemPowerOk_reg;
            readData[omc_pkg::STATUS_PLL_ON_BIT] = pllEnable;
            readData[omc_pkg::STATUS_PLL_LOCK_BIT] = pllLocked;
         end
         omc_pkg::WAKE_CAUSE_INDEX: readData[omc_pkg::WAKE_COUNT-1:0] = wakeCause_reg;
         omc_pkg::DISPLAY_CFG_INDEX: readData[omc_pkg::BOOST_LSB +: 2] = displayBoostSelect_reg;
         omc_pkg::MODE_CTRL_INDEX: begin
            readData[omc_pkg::DISPLAY_REQ_BIT] = displayOnlyRequest_reg;
            readData[omc_pkg::SLEEP_REQ_BIT] = sleepRequest_reg;
         end
         default: readHit = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= omc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= readData;
         s_axi_rresp <= readHit ? omc_pkg::RESP_OKAY : omc_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // =====================================================================
   // assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_mission_to_brownout;
      (state_reg == omc_pkg::MISSION) ##1 (state_reg == omc_pkg::BROWNOUT);
   endsequence

   sequence s_leave_display;
      (state_reg == omc_pkg::DISPLAY_ONLY) ##1 (state_reg != omc_pkg::DISPLAY_ONLY);
   endsequence

   property p_power_up;
      (state_reg == omc_pkg::POWER_UP && systemPowerOk_reg && pllLocked)
         |=> (state_reg == omc_pkg::MISSION) && (modeCode == omc_pkg::MODE_CODE_MISSION);
   endproperty
   a_power_up: assert property (p_power_up) else $error("power up did not reach mission");

   property p_power_ok;
      !supplyAboveThreshold ##1 (state_reg == omc_pkg::MISSION)
         |=> (state_reg == omc_pkg::BROWNOUT) && batterySupplySelect;
   endproperty
   a_power_ok: assert property (p_power_ok) else $error("supply loss not seen");

   property p_no_restart_brownout;
      s_mission_to_brownout |-> !cpuRestart;
   endproperty
   a_no_restart_brownout: assert property (p_no_restart_brownout)
      else $error("restart on mission to brownout");

   property p_sleep_request;
      (state_reg == omc_pkg::BROWNOUT && !systemPowerOk_reg && sleepRequest_reg)
         |=> (state_reg == omc_pkg::SLEEP) && !pllEnable && !coreEnable;
   endproperty
   a_sleep_request: assert property (p_sleep_request) else $error("sleep not entered");

   property p_brownout_enables;
      (state_reg == omc_pkg::BROWNOUT)
         |-> batterySupplySelect && !computeEnable && coreEnable && pllEnable;
   endproperty
   a_brownout_enables: assert property (p_brownout_enables)
      else $error("brownout enables wrong");

   property p_power_priority;
      (state_reg inside {omc_pkg::DISPLAY_ONLY, omc_pkg::SLEEP} && systemPowerOk_reg)
         |=> (state_reg == omc_pkg::MISSION) ##0 cpuRestart;
   endproperty
   a_power_priority: assert property (p_power_priority)
      else $error("power return not honoured");

   property p_wake;
      (state_reg == omc_pkg::SLEEP && !systemPowerOk_reg && wakeAny)
         |=> (state_reg == omc_pkg::BROWNOUT)
             && ((wakeCause_reg & $past(wakeEvents)) == $past(wakeEvents));
   endproperty
   // causes are sticky, so older uncleared bits may still stand beside the new ones
   a_wake: assert property (p_wake) else $error("wake did not reach brownout");

   property p_mission_enables;
      (state_reg == omc_pkg::MISSION) |-> computeEnable && dataRamRetain && nvRamRetain;
   endproperty
   a_mission_enables: assert property (p_mission_enables)
      else $error("mission enables wrong");

   property p_display_pll;
      (state_reg == omc_pkg::DISPLAY_ONLY)
         |-> (pllEnable == (displayBoostSelect_reg == omc_pkg::BOOST_ACTIVE)) && !coreEnable;
   endproperty
   a_display_pll: assert property (p_display_pll) else $error("display PLL wrong");

   property p_mission_request;
      (state_reg == omc_pkg::MISSION && systemPowerOk_reg && displayOnlyRequest_reg
       && !sleepRequest_reg && supplyAboveThreshold)
         |=> (state_reg == omc_pkg::DISPLAY_ONLY) ##1 (state_reg == omc_pkg::MISSION);
   endproperty
   a_mission_request: assert property (p_mission_request)
      else $error("mission request pass wrong");

   property p_display_exit;
      s_leave_display |-> cpuRestart && !displayOnlyRequest_reg;
   endproperty
   a_display_exit: assert property (p_display_exit) else $error("no restart on exit");

endmodule

// ---- logic/omc_pkg.sv ----
// shared constants and types of the operating mode controller
package omc_pkg;

   // =====================================================================
   // register indices (byte address is four times the index)
   localparam logic [13:0] STATUS_INDEX = 14'h0000;
   localparam logic [13:0] WAKE_CAUSE_INDEX = 14'h0001;
   localparam logic [13:0] DISPLAY_CFG_INDEX = 14'h2401;
   localparam logic [13:0] MODE_CTRL_INDEX = 14'h28B2;

   // =====================================================================
   // field positions
   localparam int DISPLAY_REQ_BIT = 6;
   localparam int SLEEP_REQ_BIT = 7;
   localparam int BOOST_LSB = 6;
   localparam logic [1:0] BOOST_ACTIVE = 2'h2;
   localparam int STATUS_MODE_LSB = 0;
   localparam int STATUS_POWER_OK_BIT = 3;
   localparam int STATUS_PLL_ON_BIT = 4;
   localparam int STATUS_PLL_LOCK_BIT = 5;

   // =====================================================================
   // wake sources
   localparam int WAKE_COUNT = 7;
   localparam int WAKE_TIMER_BIT = 0;
   localparam int WAKE_BUTTON_BIT = 1;
   localparam int WAKE_EDGE_PIN_BIT = 2;
   localparam int WAKE_LEVEL_A_BIT = 3;
   localparam int WAKE_LEVEL_B_BIT = 4;
   localparam int WAKE_SERIAL_RX_BIT = 5;
   localparam int WAKE_OPTICAL_RX_BIT = 6;
   // receive lines idle high, so activity is taken as a start-bit fall
   localparam logic [6:0] WAKE_RISE_MASK = 7'h07;
   localparam logic [6:0] WAKE_FALL_MASK = 7'h60;

   // =====================================================================
   // reset values and codes
   localparam logic [1:0] BOOST_RESET = 2'h0;
   localparam logic [6:0] WAKE_CAUSE_RESET = 7'h00;
   localparam logic [2:0] MODE_CODE_MISSION = 3'h0;
   localparam logic [2:0] MODE_CODE_BROWNOUT = 3'h1;
   localparam logic [2:0] MODE_CODE_DISPLAY = 3'h2;
   localparam logic [2:0] MODE_CODE_SLEEP = 3'h3;
   localparam logic [2:0] MODE_CODE_POWER_UP = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      POWER_UP,
      MISSION,
      BROWNOUT,
      DISPLAY_ONLY,
      SLEEP
   } omc_state_type;

endpackage

// ---- logic/omc_wake_detect.sv ----
// wake event detector: one registered event flag per wake source
module omc_wake_detect (
   input wire logic clk, // system clock
   input wire logic reset, // asynchronous reset, active high
   input wire logic [omc_pkg::WAKE_COUNT-1:0] wakeSources, // raw source levels
   output logic [omc_pkg::WAKE_COUNT-1:0] wakeEvents // one flag per source
);

   logic [omc_pkg::WAKE_COUNT-1:0] sourcePrev_reg;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sourcePrev_reg <= {omc_pkg::WAKE_COUNT{1'b0}};
      end else begin
         sourcePrev_reg <= wakeSources;
      end
   end

   // =====================================================================
   // per source: rising edge, falling edge or plain high level
   genvar i;
   generate
      for (i = 0; i < omc_pkg::WAKE_COUNT; i++) begin : gen_source
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               wakeEvents[i] <= 1'b0;
            end else if (omc_pkg::WAKE_RISE_MASK[i]) begin
               wakeEvents[i] <= wakeSources[i] & ~sourcePrev_reg[i];
            end else if (omc_pkg::WAKE_FALL_MASK[i]) begin
               wakeEvents[i] <= ~wakeSources[i] & sourcePrev_reg[i];
            end else begin
               wakeEvents[i] <= wakeSources[i];
            end
         end
      end
   endgenerate

endmodule

// ---- bench/omc_supply_model.sv ----
// supply comparator and PLL lock model facing the controller
module omc_supply_model (
   input wire logic clk, // system clock
   input wire logic reset, // asynchronous reset
   input wire logic powerOn, // bench: system supply present
   output logic supplyAboveThreshold, // comparator output
   output logic pllLocked // PLL stable
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] lockCount_reg;
   assign supplyAboveThreshold = powerOn;
   // lock comes late so the controller has to wait for it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) lockCount_reg <= 3'h0;
      else if (lockCount_reg != 3'h7) lockCount_reg <= lockCount_reg + 3'h1;
   end
   assign pllLocked = (lockCount_reg == 3'h7);
endmodule

// ---- bench/testbench.sv ----
// self-checking bench of the operating mode controller
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset, powerOn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdv, r;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic supplyAboveThreshold, pllLocked, computeEnable, coreEnable, displayEnable, pllEnable;
   logic batterySupplySelect, dataRamRetain, nvRamRetain, alwaysOnEnable, cpuRestart, seen;
   logic wakeTimerExpired, pushbuttonInput, edgeWakePin, levelWakePinA, levelWakePinB;
   logic serialReceivePin, opticalReceivePin;
   logic [2:0] modeCode;
   logic [6:0] wk;
   logic [31:0] seed = 32'hC09A;
   int err_count, check_count;
   assign {opticalReceivePin, serialReceivePin, levelWakePinB, levelWakePinA} = wk[6:3];
   assign {edgeWakePin, pushbuttonInput, wakeTimerExpired} = wk[2:0];
   omc_mode_controller u_dut (.*);
   omc_supply_model u_sup (.*);
   // =====================================================
   // helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [6:0] outs(input logic [2:0] m);
      case (m)
         3'h0: return 7'h77;
         3'h1: return 7'h3F;
         3'h2: return 7'h1B;
         default: return 7'h0B;
      endcase
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic end_of_test();
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wrReg(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      chk(s_axi_bresp, omc_pkg::RESP_OKAY);
      s_axi_bready <= 1'h0;
   endtask
   task automatic rdReg(input logic [15:0] a);
      @(posedge clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      {rdv, rr} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'h0;
   endtask
   // restart pulse only shows for one cycle, so it is collected while waiting
   task automatic waitMode(input logic [2:0] m);
      seen = 1'h0;
      for (int i = 0; i < 20 && modeCode !== m; i++) begin
         @(posedge clk);
         #1 seen |= cpuRestart;
      end
      chk(modeCode, m);
      chk({computeEnable, coreEnable, displayEnable, batterySupplySelect, dataRamRetain,
         nvRamRetain, alwaysOnEnable}, outs(m));
   endtask
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   initial begin
      #400000 err_count++;
      end_of_test();
   end
   // =====================================================
   // main sequence
   initial begin
      {reset, powerOn, wk, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = {2'h2, 7'h60, 3'h0};
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 66'h0;
      s_axi_wstrb = 4'hF;
      {err_count, check_count} = 0;
      repeat (12) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      powerOn <= 1'h1;
      waitMode(omc_pkg::MODE_CODE_MISSION);
      rdReg(16'h0100);
      chk(rr, omc_pkg::RESP_SLVERR);
      // request on system power: one cycle of display-only, then back with a restart
      wrReg({omc_pkg::MODE_CTRL_INDEX, 2'h0}, 32'h40);
      #1 chk(modeCode, omc_pkg::MODE_CODE_DISPLAY);
      @(posedge clk);
      #1 chk(cpuRestart, 1'h1);
      waitMode(omc_pkg::MODE_CODE_MISSION);
      rdReg({omc_pkg::MODE_CTRL_INDEX, 2'h0});
      chk(rdv, 32'h0);
      for (int i = 0; i < omc_pkg::WAKE_COUNT; i++) begin
         @(posedge clk);
         powerOn <= 1'h0;
         waitMode(omc_pkg::MODE_CODE_BROWNOUT);
         chk(seen, 1'h0);
         // firmware keeps its clock settings, so the PLL stays as it was
         chk(pllEnable, 1'h1);
         rdReg({omc_pkg::STATUS_INDEX, 2'h0});
         chk(rdv[omc_pkg::STATUS_POWER_OK_BIT], 1'h0);
         r = xs();
         // corner cases first: display-only with boost active, then sleep
         if (i < 2) r = i ? 32'h1 : 32'h80;
         wrReg({omc_pkg::DISPLAY_CFG_INDEX, 2'h0}, {24'h0, r[7:6], 6'h0});
         wrReg({omc_pkg::MODE_CTRL_INDEX, 2'h0}, 32'h40 << r[0]);
         waitMode(r[0] ? omc_pkg::MODE_CODE_SLEEP : omc_pkg::MODE_CODE_DISPLAY);
         chk(pllEnable, !r[0] && r[7:6] === omc_pkg::BOOST_ACTIVE);
         @(posedge clk);
         wk <= wk ^ (7'h1 << i);
         waitMode(omc_pkg::MODE_CODE_BROWNOUT);
         chk(seen, 1'h1);
         rdReg({omc_pkg::WAKE_CAUSE_INDEX, 2'h0});
         chk(rdv, 32'h1 << i);
         wrReg({omc_pkg::WAKE_CAUSE_INDEX, 2'h0}, rdv);
         @(posedge clk);
         {wk, powerOn} <= {7'h60, 1'h1};
         waitMode(omc_pkg::MODE_CODE_MISSION);
         // firmware soft reset puts the display config back to its default
         wrReg({omc_pkg::DISPLAY_CFG_INDEX, 2'h0}, 32'h0);
      end
      @(posedge clk);
      powerOn <= 1'h0;
      waitMode(omc_pkg::MODE_CODE_BROWNOUT);
      wrReg({omc_pkg::MODE_CTRL_INDEX, 2'h0}, 32'h80);
      waitMode(omc_pkg::MODE_CODE_SLEEP);
      @(posedge clk);
      {wk, powerOn} <= {7'h61, 1'h1};
      repeat (2) @(posedge clk);
      #1 chk(modeCode, omc_pkg::MODE_CODE_MISSION);
      end_of_test();
   end
endmodule
